// ### rtl/peak_detector.sv
`timescale 1ns/100ps
module peak_detector (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire sigmon_pkg::sample_t         sample,
  input  wire logic                        enable,
  input  wire logic [23:0]                 period,
  input  wire logic                        restart,
  output logic      [sigmon_pkg::MAG_W-1:0] meas_q
);
  import sigmon_pkg::*;

  logic [23:0]      count_q;
  logic [MAG_W-1:0] peak_q;
  logic [MAG_W-1:0] mag;
  logic             period_end;

  // ==========================================================================
  // Magnitude and period end
  always_comb begin
    mag        = sample.data[12] ? MAG_W'(-sample.data) : MAG_W'(sample.data);
    period_end = (count_q + 24'h000001 >= period);
  end

  // ==========================================================================
  // Period counter in clk_sys cycles
  always_ff @(posedge clk_sys) begin
    if (rst || restart || !enable || period_end) begin
      count_q <= 24'h000000; // RULE1
    end else begin
      count_q <= count_q + 24'h000001;
    end
  end

  // ==========================================================================
  // Running peak, latched at period end
  always_ff @(posedge clk_sys) begin
    if (rst || restart || !enable) begin
      peak_q <= '0;
    end else if (period_end) begin
      peak_q <= '0;
    end else if (sample.valid && mag > peak_q) begin
      peak_q <= mag;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meas_q <= '0;
    end else if (enable && period_end && !restart) begin
      meas_q <= (sample.valid && mag > peak_q) ? mag : peak_q;
    end
  end

endmodule

// ### rtl/sigmon_pkg.sv
package sigmon_pkg;

  // ==========================================================================
  // Register indices (byte address = 4 * index)
  localparam logic [9:0]  IDX_DWELL_LO   = 10'h24B;
  localparam logic [9:0]  IDX_DWELL_HI   = 10'h24C;
  localparam logic [9:0]  IDX_SYNC_CTRL  = 10'h26F;
  localparam logic [9:0]  IDX_MON_CTRL   = 10'h270;
  localparam logic [9:0]  IDX_PERIOD0    = 10'h271;
  localparam logic [9:0]  IDX_PERIOD1    = 10'h272;
  localparam logic [9:0]  IDX_PERIOD2    = 10'h273;
  localparam logic [9:0]  IDX_RES_CTRL   = 10'h274;
  localparam logic [9:0]  IDX_RESULT0    = 10'h275;
  localparam logic [9:0]  IDX_RESULT1    = 10'h276;
  localparam logic [9:0]  IDX_RESULT2    = 10'h277;

  // ==========================================================================
  // Field positions
  localparam int          POS_PEAK_EN    = 1;
  localparam int          POS_RES_SEL    = 0;
  localparam int          POS_RES_UPD    = 4;
  localparam int          PEAK_LSB       = 7;

  // ==========================================================================
  // Reset values and widths
  localparam logic [23:0] PERIOD_RST     = 24'h000080;
  localparam logic [15:0] DWELL_RST      = 16'h0000;
  localparam logic        RES_SEL_RST    = 1'h1;
  localparam logic        RES_SEL_PEAK   = 1'h1;
  localparam logic [19:0] RESULT_RST     = 20'h00000;
  localparam int          MAG_W          = 13;

  typedef enum logic [1:0] {
    SYNC_OFF,
    SYNC_CONT,
    SYNC_ONCE,
    SYNC_RSVD
  } sync_mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic              valid;
    logic signed [12:0] data;
  } sample_t;

endpackage

// ### rtl/signal_monitor_peak_registers.sv
// Summary of operation
// [RULE1] 24-bit period over three bytes, low resets 0x80
// [RULE2] Read-only 20-bit result, bytes at consecutive registers
// [RULE3] Peak magnitude placed in result bits 19:7
// [RULE4] Selection 1 means peak; resets to 1
// [RULE5] Update bit copies measurement, self-clears, results hold
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
module signal_monitor_peak_registers (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire sigmon_pkg::avmm_req_t avs_req,
  output logic                       avs_waitrequest,
  output logic [31:0]                avs_readdata,
  input  wire sigmon_pkg::sample_t   sample,
  input  wire logic                  sync_pin,
  output logic [15:0]                dwell_time
);
  import sigmon_pkg::*;

  logic [15:0]      dwell_q;
  logic [1:0]       sync_mode_q;
  logic             peak_en_q;
  logic [23:0]      period_q;
  logic             res_sel_q;
  logic [19:0]      result_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [2:0]       sync_sh_q;
  logic             sync_lvl_q;
  logic             sync_evt;
  logic             restart;
  logic             wr_fire;
  logic             upd_fire;
  logic [MAG_W-1:0] meas;

  function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
  endfunction

  function automatic logic wr_to(input avmm_req_t r, input logic [9:0] idx);
    wr_to = r.write && r.byteenable[0] && hit(r.address, idx);
  endfunction

  // ==========================================================================
  // Avalon handshake
  always_comb begin
    wr_fire  = avs_req.write && !wait_q;
    upd_fire = wr_fire && wr_to(avs_req, IDX_RES_CTRL) && avs_req.writedata[POS_RES_UPD];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_q <= 1'h1;
    end else if (wait_q && (avs_req.read || avs_req.write)) begin
      wait_q <= 1'h0;
    end else begin
      wait_q <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else if (wait_q && avs_req.read) begin
      rdata_q <= 32'h00000000;
      if (avs_req.address[1:0] == 2'h0) begin
        unique case (avs_req.address[11:2])
          IDX_DWELL_LO:  rdata_q[7:0] <= dwell_q[7:0];
          IDX_DWELL_HI:  rdata_q[7:0] <= dwell_q[15:8];
          IDX_SYNC_CTRL: rdata_q[1:0] <= sync_mode_q;
          IDX_MON_CTRL:  rdata_q[POS_PEAK_EN] <= peak_en_q;
          IDX_PERIOD0:   rdata_q[7:0] <= period_q[7:0];
          IDX_PERIOD1:   rdata_q[7:0] <= period_q[15:8];
          IDX_PERIOD2:   rdata_q[7:0] <= period_q[23:16];
          IDX_RES_CTRL:  rdata_q[POS_RES_SEL] <= res_sel_q; // RULE5
          IDX_RESULT0:   rdata_q[7:0] <= result_q[7:0]; // RULE2
          IDX_RESULT1:   rdata_q[7:0] <= result_q[15:8]; // RULE2
          IDX_RESULT2:   rdata_q[3:0] <= result_q[19:16];
          default:       rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign dwell_time      = dwell_q;

  // ==========================================================================
  // Writable registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dwell_q <= DWELL_RST;
    end else if (wr_fire) begin
      if (wr_to(avs_req, IDX_DWELL_LO)) dwell_q[7:0] <= avs_req.writedata[7:0];
      if (wr_to(avs_req, IDX_DWELL_HI)) dwell_q[15:8] <= avs_req.writedata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      period_q <= PERIOD_RST; // RULE1
    end else if (wr_fire) begin
      if (wr_to(avs_req, IDX_PERIOD0)) period_q[7:0] <= avs_req.writedata[7:0]; // RULE1
      if (wr_to(avs_req, IDX_PERIOD1)) period_q[15:8] <= avs_req.writedata[7:0]; // RULE1
      if (wr_to(avs_req, IDX_PERIOD2)) period_q[23:16] <= avs_req.writedata[7:0]; // RULE1
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      peak_en_q <= 1'h0;
      res_sel_q <= RES_SEL_RST; // RULE4
    end else if (wr_fire) begin
      if (wr_to(avs_req, IDX_MON_CTRL)) peak_en_q <= avs_req.writedata[POS_PEAK_EN];
      if (wr_to(avs_req, IDX_RES_CTRL)) res_sel_q <= avs_req.writedata[POS_RES_SEL]; // RULE4
    end
  end

  // One-shot mode returns to off after its event; a software write wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_mode_q <= SYNC_OFF;
    end else if (wr_fire && wr_to(avs_req, IDX_SYNC_CTRL)) begin
      sync_mode_q <= avs_req.writedata[1:0];
    end else if (sync_evt && sync_mode_q == SYNC_ONCE) begin
      sync_mode_q <= SYNC_OFF;
    end
  end

  // ==========================================================================
  // Sync pin synchroniser and edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_sh_q  <= 3'h0;
      sync_lvl_q <= 1'h0;
    end else begin
      sync_sh_q <= {sync_sh_q[1:0], sync_pin};
      if (sync_sh_q[1] == sync_sh_q[2]) sync_lvl_q <= sync_sh_q[2];
    end
  end

  always_comb begin
    sync_evt = (sync_sh_q[1] == sync_sh_q[2]) && sync_sh_q[2] && !sync_lvl_q;
    restart  = sync_evt && (sync_mode_q == SYNC_CONT || sync_mode_q == SYNC_ONCE);
  end

  // ==========================================================================
  // Measurement and result
  peak_detector u_peak (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sample  (sample),
    .enable  (peak_en_q),
    .period  (period_q),
    .restart (restart),
    .meas_q  (meas)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_q <= RESULT_RST;
    end else if (upd_fire) begin // RULE5
      if (res_sel_q == RES_SEL_PEAK) begin
        result_q <= {meas, 7'h00}; // RULE3
      end else begin
        result_q <= RESULT_RST;
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence s_update_write;
    wr_fire && wr_to(avs_req, IDX_RES_CTRL) && avs_req.writedata[POS_RES_UPD];
  endsequence

  a_period_reset_value: assert property (@(posedge clk_sys) // RULE1
    $past(rst) && !rst |-> period_q == PERIOD_RST && dwell_q == DWELL_RST)
    else $error("Period reset value wrong");

  a_result_readonly: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    wr_fire && hit(avs_req.address, IDX_RESULT0) |=> $stable(result_q))
    else $error("Result changed by a write");

  a_peak_placement: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
    s_update_write ##0 (res_sel_q == RES_SEL_PEAK) |=> result_q == {$past(meas), 7'h00})
    else $error("Peak not placed at result bits 19:7");

  a_sel_reset: assert property (@(posedge clk_sys) // RULE4
    $past(rst) && !rst |-> res_sel_q == RES_SEL_RST)
    else $error("Selection reset wrong");

  a_result_hold: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
    !upd_fire |=> $stable(result_q))
    else $error("Result changed without update");

  a_update_selfclear: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
    avs_req.read && wait_q && hit(avs_req.address, IDX_RES_CTRL)
      |=> !avs_waitrequest && avs_readdata[POS_RES_UPD] == 1'h0)
    else $error("Update bit not self-clearing");

  a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle");

  a_answer_next_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    wait_q && (avs_req.read || avs_req.write) |=> !avs_waitrequest)
    else $error("Request not answered in one cycle");

  a_period_write: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    wr_fire && wr_to(avs_req, IDX_PERIOD0) |=> period_q[7:0] == $past(avs_req.writedata[7:0]))
    else $error("Period low byte not written");

  a_reserved_sel: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
    upd_fire && res_sel_q != RES_SEL_PEAK |=> result_q == RESULT_RST)
    else $error("Reserved selection did not clear result");

  a_once_revert: assert property (@(posedge clk_sys) disable iff (rst)
    sync_evt && sync_mode_q == SYNC_ONCE && !(wr_fire && wr_to(avs_req, IDX_SYNC_CTRL))
      |=> sync_mode_q == SYNC_OFF)
    else $error("One-shot sync mode did not return to off");

endmodule

// ### verif/test_signal_monitor_peak_registers.sv
`timescale 1ns/100ps
module test_signal_monitor_peak_registers;
  import sigmon_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  avmm_req_t   avs_req = '0;
  logic        avs_waitrequest;
  logic [31:0] avs_readdata;
  sample_t     sample = '0;
  logic        sync_pin = 1'b0;
  logic [15:0] dwell_time;
  int          errors = 0;
  int          cmp_count = 0;
  int          seed = 35919;
  int          mdl [int];
  int          d;
  int          m;
  int          res;
  logic [7:0]  q;
  logic [9:0]  ridx [11] = '{IDX_DWELL_LO, IDX_DWELL_HI, IDX_SYNC_CTRL, IDX_MON_CTRL,
    IDX_PERIOD0, IDX_PERIOD1, IDX_PERIOD2, IDX_RES_CTRL, IDX_RESULT0, IDX_RESULT1, IDX_RESULT2};
  logic [7:0]  msk [7] = '{8'hFF, 8'hFF, 8'h03, 8'h02, 8'hFF, 8'hFF, 8'hFF};

  always #5 clk_sys = ~clk_sys;

  signal_monitor_peak_registers i_dut (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .avs_req         (avs_req),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .sample          (sample),
    .sync_pin        (sync_pin),
    .dwell_time      (dwell_time)
  );

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic is_rd, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_req <= '{read: is_rd, write: !is_rd, address: {idx, 2'h0},
                 byteenable: 4'hF, writedata: {24'h000000, wd}};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    q = avs_readdata[7:0];
    avs_req <= '0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    bus(1'b0, idx, wd);
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00);
    chk($sformatf("reg %h", idx), {24'h000000, q}, {24'h000000, exp});
  endtask

  task automatic res_chk;
    rchk(IDX_RESULT0, res[7:0]);
    rchk(IDX_RESULT1, res[15:8]);
    rchk(IDX_RESULT2, res[19:16]);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end

  // ==========================================================================
  // Tests
  initial begin
    foreach (ridx[i]) mdl[ridx[i]] = 0;
    mdl[IDX_PERIOD0] = 8'h80;
    mdl[IDX_RES_CTRL] = 8'h01;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ridx[i]) rchk(ridx[i], mdl[ridx[i]][7:0]);
    rchk(10'h250, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      mdl[ridx[i]] = $random(seed) & msk[i];
      wr(ridx[i], mdl[ridx[i]][7:0]);
    end
    for (int i = 0; i < 7; i++) rchk(ridx[i], mdl[ridx[i]][7:0]);
    chk("dwell_time", {16'h0000, dwell_time}, mdl[IDX_DWELL_HI] * 256 + mdl[IDX_DWELL_LO]);
    $display("test registers done");
    wr(IDX_PERIOD0, 8'h04);
    wr(IDX_PERIOD1, 8'h00);
    wr(IDX_PERIOD2, 8'h00);
    wr(IDX_MON_CTRL, 8'h02);
    res = 0;
    for (int k = 0; k < 5; k++) begin
      d = (k == 0) ? -4095 : $random(seed) % 4096;
      m = (d < 0) ? -d : d;
      sample <= '{valid: 1'b1, data: 13'(d)};
      repeat (20) @(posedge clk_sys);
      res_chk();
      wr(IDX_RES_CTRL, 8'h11);
      res = m << 7;
      res_chk();
      wr(IDX_RESULT0, 8'h5A);
      rchk(IDX_RESULT0, res[7:0]);
      rchk(IDX_RES_CTRL, 8'h01);
    end
    $display("test peak done");
    for (int s = 2; s > 0; s--) begin
      wr(IDX_SYNC_CTRL, 8'(s));
      sync_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sync_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rchk(IDX_SYNC_CTRL, (s == 2) ? 8'h00 : 8'h01);
    end
    $display("test sync done");
    wr(IDX_RES_CTRL, 8'h00);
    wr(IDX_RES_CTRL, 8'h10);
    res = 0;
    res_chk();
    rchk(IDX_RES_CTRL, 8'h00);
    $display("test selection done");
    wrap_up();
  end
endmodule
